/* hdl/position_option_pkg.sv */
package position_option_pkg;

    // Object dictionary indices
    localparam logic [15:0] IDX_POS_OPTION  = 16'h60f2;
    localparam logic [15:0] IDX_FOLLOW_ERR  = 16'h60f4;
    localparam logic [15:0] IDX_INPUT_LEVEL = 16'h60fd;

    // Reset values
    localparam logic [15:0] POS_OPTION_RST  = 16'h0001;
    localparam logic [31:0] FOLLOW_ERR_RST  = 32'h0000_0000;
    localparam logic [31:0] INPUT_LEVEL_RST = 32'h0000_0000;

    // Option word fields
    localparam int REL_BASE_LSB   = 0;
    localparam int RELEASE_LSB    = 4;
    localparam int ROTARY_DIR_LSB = 6;

    // Control and status bits
    localparam int CTRL_NEW_SETPOINT = 4;
    localparam int CTRL_RELATIVE     = 6;
    localparam int STATUS_ACK        = 12;

    // Input word positions
    localparam int IN_NEG_LIMIT  = 0;
    localparam int IN_POS_LIMIT  = 1;
    localparam int IN_HOME       = 2;
    localparam int IN_GENERAL_LSB = 16;

    // Field codes
    localparam logic [1:0] REL_PREV_TARGET = 2'h0;
    localparam logic [1:0] REL_RAMP_OUTPUT = 2'h1;
    localparam logic [1:0] REL_ACTUAL_POS  = 2'h2;
    localparam logic [1:0] REL_NONE        = 2'h0;
    localparam logic [1:0] RELEASE_HOST    = 2'h0;
    localparam logic [1:0] RELEASE_AT_GOAL = 2'h1;
    localparam logic [1:0] RELEASE_ASAP    = 2'h2;
    localparam logic [1:0] ROT_LINEAR      = 2'h0;
    localparam logic [1:0] ROT_NEG_ONLY    = 2'h1;
    localparam logic [1:0] ROT_POS_ONLY    = 2'h2;
    localparam logic [1:0] ROT_SHORTEST    = 2'h3;

    // Move direction encoding
    localparam logic [1:0] DIR_POS = 2'h1;
    localparam logic [1:0] DIR_NEG = 2'h2;

    typedef enum logic [1:0] {
        REQ_IDLE,
        REQ_ACKED,
        REQ_RELEASED
    } req_state_type;

endpackage

/* hdl/positioning_option_logic.sv */
`timescale 1ns/1ps
module positioning_option_logic
    import position_option_pkg::*;
#(
    parameter logic [7:0] GENERAL_IN_MASK = 8'hff
) (
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               rst_n,
    // Object access
    input  wire logic [15:0]        obj_index,
    input  wire logic               obj_wr,
    input  wire logic               obj_rd,
    input  wire logic [31:0]        obj_wdata,
    output logic      [31:0]        obj_rdata,
    output logic                    obj_rvalid,
    output logic                    obj_err,
    // Control and status word
    input  wire logic               ctrl_wr,
    input  wire logic [15:0]        ctrl_wdata,
    output logic      [15:0]        ctrl_word,
    output logic                    setpoint_ack,
    // Trajectory interface
    input  wire logic signed [31:0] target_position,
    input  wire logic signed [31:0] ramp_output,
    input  wire logic signed [31:0] actual_position,
    input  wire logic signed [31:0] range_min,
    input  wire logic signed [31:0] range_max,
    input  wire logic               setpoint_ready,
    input  wire logic               target_reached,
    output logic signed [31:0]      move_target,
    output logic      [1:0]         move_direction,
    output logic                    move_start,
    // Switch pins
    input  wire logic               negative_limit_input,
    input  wire logic               positive_limit_input,
    input  wire logic               home_switch_input,
    input  wire logic [7:0]         general_input
);

    logic [15:0]        option_r;
    logic [15:0]        ctrl_r;
    logic [15:0]        ctrl_nxt;
    req_state_type      req_r;
    req_state_type      req_nxt;
    logic signed [31:0] prev_target_r;
    logic signed [31:0] follow_err_r;
    logic [31:0]        input_word_r;
    logic [10:0]        pin_s1_r;
    logic [10:0]        pin_s2_r;
    logic signed [31:0] raw_target_r;

    // Option fields
    wire [1:0] relative_base_select    = option_r[REL_BASE_LSB +: 2];
    wire [1:0] setpoint_release_select = option_r[RELEASE_LSB +: 2];
    wire [1:0] rotary_direction_select = option_r[ROTARY_DIR_LSB +: 2];

    wire new_setpoint = ctrl_r[CTRL_NEW_SETPOINT];
    wire relative_cmd = ctrl_r[CTRL_RELATIVE];
    wire accept       = (req_r == REQ_IDLE) && new_setpoint && setpoint_ready;

    // Base of a move; absolute moves use no base
    wire [1:0] base_code = relative_cmd ? relative_base_select : REL_NONE;
    wire signed [31:0] base_value =
        !relative_cmd                      ? 32'sh0000_0000 :
        (base_code == REL_RAMP_OUTPUT)     ? ramp_output :
        (base_code == REL_ACTUAL_POS)      ? actual_position :
                                             prev_target_r;
    wire signed [31:0] raw_target = base_value + target_position;

    // Range wrap
    wire signed [32:0] span =
        33'(range_max) - 33'(range_min) + 33'sh0_0000_0001;
    wire signed [31:0] wrapped_target =
        (raw_target > range_max) ? 32'(33'(raw_target) - span) :
        (raw_target < range_min) ? 32'(33'(raw_target) + span) :
                                   raw_target;

    // Direction choice
    wire signed [32:0] diff_raw =
        33'(wrapped_target) - 33'(actual_position);
    wire signed [32:0] diff_turn =
        (diff_raw < 0) ? diff_raw + span : diff_raw;
    wire               short_pos = diff_turn < (span >>> 1);
    wire [1:0] dir_sel =
        (rotary_direction_select == ROT_NEG_ONLY) ? DIR_NEG :
        (rotary_direction_select == ROT_POS_ONLY) ? DIR_POS :
        (rotary_direction_select == ROT_SHORTEST) ?
            (short_pos ? DIR_POS : DIR_NEG) :
        (diff_raw < 0 ? DIR_NEG : DIR_POS);

    // Handshake sequencing
    wire release_on = (setpoint_release_select == RELEASE_AT_GOAL) ||
                      (setpoint_release_select == RELEASE_ASAP);
    wire goal_release = (setpoint_release_select == RELEASE_AT_GOAL) &&
                        target_reached;
    wire asap_release = setpoint_release_select == RELEASE_ASAP;

    always_comb begin
        req_nxt  = req_r;
        ctrl_nxt = ctrl_r;
        unique case (req_r)
            REQ_IDLE: begin
                if (accept)
                    req_nxt = REQ_ACKED;
            end
            REQ_ACKED: begin
                if (release_on && (goal_release || asap_release)) begin
                    ctrl_nxt[CTRL_NEW_SETPOINT] = 1'b0;
                    req_nxt = REQ_RELEASED;
                end else if (!new_setpoint) begin
                    req_nxt = REQ_IDLE;
                end
            end
            REQ_RELEASED: begin
                req_nxt = REQ_IDLE;
            end
        endcase
        // Host write wins over the device's own clear
        if (ctrl_wr)
            ctrl_nxt = ctrl_wdata;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            req_r  <= REQ_IDLE;
            ctrl_r <= 16'h0000;
        end else begin
            req_r  <= req_nxt;
            ctrl_r <= ctrl_nxt;
        end
    end

    // Ack outlives the request bit by one cycle
    assign ctrl_word    = ctrl_r;
    assign setpoint_ack = (req_r == REQ_ACKED) ||
                          (req_r == REQ_RELEASED);

    // Accepted move
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prev_target_r  <= 32'sh0000_0000;
            move_target    <= 32'sh0000_0000;
            move_direction <= DIR_POS;
            move_start     <= 1'b0;
            raw_target_r   <= 32'sh0000_0000;
        end else begin
            move_start <= accept;
            if (accept) begin
                prev_target_r  <= wrapped_target;
                move_target    <= wrapped_target;
                move_direction <= dir_sel;
                raw_target_r   <= raw_target;
            end
        end
    end

    // Following error and input word
    wire [10:0] pins = {general_input, home_switch_input,
                        positive_limit_input, negative_limit_input};

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pin_s1_r     <= 11'h000;
            pin_s2_r     <= 11'h000;
            input_word_r <= INPUT_LEVEL_RST;
            follow_err_r <= FOLLOW_ERR_RST;
        end else begin
            pin_s1_r     <= pins;
            pin_s2_r     <= pin_s1_r;
            follow_err_r <= ramp_output - actual_position;
            input_word_r <= {8'h00,
                             pin_s2_r[10:3] & GENERAL_IN_MASK,
                             13'h0000, pin_s2_r[2:0]};
        end
    end

    // Object access
    wire hit_option = obj_index == IDX_POS_OPTION;
    wire hit_ferr   = obj_index == IDX_FOLLOW_ERR;
    wire hit_input  = obj_index == IDX_INPUT_LEVEL;
    wire hit_any    = hit_option || hit_ferr || hit_input;
    wire bad_access = (obj_wr && !hit_option) || (obj_rd && !hit_any);
    wire [31:0] read_mux =
        hit_option ? {16'h0000, option_r} :
        hit_ferr   ? follow_err_r :
        hit_input  ? input_word_r : 32'h0000_0000;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            option_r   <= POS_OPTION_RST;
            obj_rdata  <= 32'h0000_0000;
            obj_rvalid <= 1'b0;
            obj_err    <= 1'b0;
        end else begin
            if (obj_wr && hit_option)
                option_r <= obj_wdata[15:0];
            obj_rvalid <= obj_rd && hit_any;
            obj_err    <= bad_access;
            if (obj_rd)
                obj_rdata <= read_mux;
        end
    end

    a_option_reset: assert property (@(posedge clock)
        $past(!rst_n) |-> option_r == POS_OPTION_RST)
        else $error("option word not at reset value");

    a_absolute_move: assert property (@(posedge clock)
        disable iff (!rst_n)
        accept && !relative_cmd |=> raw_target_r == $past(target_position))
        else $error("absolute move used a base");

    a_base_prev: assert property (@(posedge clock)
        disable iff (!rst_n)
        accept && relative_cmd && relative_base_select == REL_PREV_TARGET
        |=> raw_target_r == $past(prev_target_r) + $past(target_position))
        else $error("relative move not based on previous target");

    a_base_ramp: assert property (@(posedge clock)
        disable iff (!rst_n)
        accept && relative_cmd && relative_base_select == REL_RAMP_OUTPUT
        |=> raw_target_r == $past(ramp_output) + $past(target_position))
        else $error("relative move not based on ramp output");

    a_base_actual: assert property (@(posedge clock)
        disable iff (!rst_n)
        accept && relative_cmd && relative_base_select == REL_ACTUAL_POS
        |=> raw_target_r == $past(actual_position) + $past(target_position))
        else $error("relative move not based on actual position");

    a_ack_after_clear: assert property (@(posedge clock)
        disable iff (!rst_n)
        req_r == REQ_ACKED && release_on && (goal_release || asap_release)
        && !ctrl_wr |=> !ctrl_word[CTRL_NEW_SETPOINT] && setpoint_ack
        ##1 !setpoint_ack)
        else $error("release order wrong");

    a_release_asap: assert property (@(posedge clock)
        disable iff (!rst_n)
        accept && asap_release && !ctrl_wr
        ##1 !ctrl_wr |=> !ctrl_word[CTRL_NEW_SETPOINT])
        else $error("immediate release missing");

    a_host_release: assert property (@(posedge clock)
        disable iff (!rst_n)
        setpoint_ack && setpoint_release_select == RELEASE_HOST
        && new_setpoint |=> setpoint_ack)
        else $error("ack dropped while host still requests");

    a_neg_only: assert property (@(posedge clock)
        disable iff (!rst_n)
        accept && rotary_direction_select == ROT_NEG_ONLY
        |=> move_direction == DIR_NEG)
        else $error("negative-only move went positive");

    a_pos_only: assert property (@(posedge clock)
        disable iff (!rst_n)
        accept && rotary_direction_select == ROT_POS_ONLY
        |=> move_direction == DIR_POS)
        else $error("positive-only move went negative");

    a_follow_err: assert property (@(posedge clock)
        disable iff (!rst_n)
        $past(rst_n) |-> follow_err_r ==
            $past(ramp_output) - $past(actual_position))
        else $error("following error stale");

    a_limit_bits: assert property (@(posedge clock)
        disable iff (!rst_n)
        $past(rst_n, 3) |-> input_word_r[IN_NEG_LIMIT] ==
            $past(negative_limit_input, 3) && input_word_r[IN_HOME] ==
            $past(home_switch_input, 3))
        else $error("switch bits do not follow pins");

    a_option_write: assert property (@(posedge clock)
        disable iff (!rst_n)
        obj_wr && hit_option |=> option_r == $past(obj_wdata[15:0]))
        else $error("option write lost");

    a_range_wrap: assert property (@(posedge clock)
        disable iff (!rst_n)
        accept |=> move_target >= $past(range_min)
            && move_target <= $past(range_max))
        else $error("target outside position range");

    a_shortest_pos: assert property (@(posedge clock)
        disable iff (!rst_n)
        accept && rotary_direction_select == ROT_SHORTEST
        && diff_raw >= 0 && diff_raw < (span >>> 1)
        |=> move_direction == DIR_POS)
        else $error("short positive path not taken");

    a_read_only: assert property (@(posedge clock)
        disable iff (!rst_n)
        obj_wr && (hit_ferr || hit_input) |=> obj_err)
        else $error("write to read-only value not refused");

    a_pos_limit_bit: assert property (@(posedge clock)
        disable iff (!rst_n)
        $past(rst_n, 3) |-> input_word_r[IN_POS_LIMIT] ==
            $past(positive_limit_input, 3))
        else $error("positive limit bit does not follow pin");

    a_general_bits: assert property (@(posedge clock)
        disable iff (!rst_n)
        $past(rst_n, 3) |-> input_word_r[IN_GENERAL_LSB +: 8] ==
            ($past(general_input, 3) & GENERAL_IN_MASK)
            && input_word_r[31:24] == 8'h00)
        else $error("general input bits wrong");

endmodule

/* verification/fieldbus_master_model.sv */
`timescale 1ns/1ps
module fieldbus_master_model (
    // Clock
    input  wire logic        clock,
    // Object and control requests
    output logic      [15:0] obj_index,
    output logic             obj_wr,
    output logic             obj_rd,
    output logic      [31:0] obj_wdata,
    output logic             ctrl_wr,
    output logic      [15:0] ctrl_wdata,
    // Answers
    input  wire logic [31:0] obj_rdata,
    input  wire logic        obj_rvalid,
    input  wire logic        obj_err
);
    initial begin
        obj_index = 16'h0;
        obj_wr = 1'b0;
        obj_rd = 1'b0;
        obj_wdata = 32'h0;
        ctrl_wr = 1'b0;
        ctrl_wdata = 16'h0;
    end

    // One object access, answer taken one edge later
    task automatic access(input logic [15:0] idx, input logic wr,
        input logic [31:0] wd, output logic [31:0] rd, output logic ok,
        output logic err);
        @(posedge clock);
        #1;
        obj_index = idx;
        obj_wr = wr;
        obj_rd = !wr;
        obj_wdata = wd;
        @(posedge clock);
        #1;
        obj_wr = 1'b0;
        obj_rd = 1'b0;
        // Released bus shows no stale values
        obj_index = ~idx;
        obj_wdata = ~wd;
        rd = obj_rdata;
        ok = obj_rvalid;
        err = obj_err;
    endtask

    task automatic control(input logic [15:0] value);
        @(posedge clock);
        #1;
        ctrl_wr = 1'b1;
        ctrl_wdata = value;
        @(posedge clock);
        #1;
        ctrl_wr = 1'b0;
        ctrl_wdata = ~value;
    endtask
endmodule

/* verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import position_option_pkg::*;
    localparam logic [7:0]         MASK = 8'h3f;
    localparam logic signed [31:0] RMIN = -32'sd1000;
    localparam logic signed [31:0] RMAX = 32'sd999;
    localparam logic [15:0] IDX [3] = '{IDX_POS_OPTION, IDX_FOLLOW_ERR,
                                        IDX_INPUT_LEVEL};
    localparam logic [31:0] RST [3] = '{32'h1, 32'h0, 32'h0};
    logic               clock, rst_n, obj_wr, obj_rd, obj_rvalid, obj_err;
    logic               ctrl_wr, setpoint_ack, setpoint_ready, move_start;
    logic               target_reached, neg, pos, home, ok, er, relv;
    logic        [15:0] obj_index, ctrl_wdata, ctrl_word, opt;
    logic        [31:0] obj_wdata, obj_rdata, rd;
    logic signed [31:0] target_position, ramp_output, actual_position;
    logic signed [31:0] move_target, prev_t, exp_t, base;
    logic        [1:0]  move_direction, rel, rls, rot;
    logic        [7:0]  general_input;
    int                 fail_count, comparisons, i;

    positioning_option_logic #(.GENERAL_IN_MASK(MASK))
        i_positioning_option_logic (
        .clock(clock), .rst_n(rst_n), .obj_index(obj_index),
        .obj_wr(obj_wr), .obj_rd(obj_rd), .obj_wdata(obj_wdata),
        .obj_rdata(obj_rdata), .obj_rvalid(obj_rvalid), .obj_err(obj_err),
        .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .ctrl_word(ctrl_word),
        .setpoint_ack(setpoint_ack), .target_position(target_position),
        .ramp_output(ramp_output), .actual_position(actual_position),
        .range_min(RMIN), .range_max(RMAX), .setpoint_ready(setpoint_ready),
        .target_reached(target_reached), .move_target(move_target),
        .move_direction(move_direction), .move_start(move_start),
        .negative_limit_input(neg), .positive_limit_input(pos),
        .home_switch_input(home), .general_input(general_input));

    fieldbus_master_model master (
        .clock(clock), .obj_index(obj_index), .obj_wr(obj_wr),
        .obj_rd(obj_rd), .obj_wdata(obj_wdata), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(ctrl_wdata), .obj_rdata(obj_rdata),
        .obj_rvalid(obj_rvalid), .obj_err(obj_err));

    function automatic logic signed [31:0] wrap(input logic signed [31:0] t);
        if (t > RMAX) return t - (RMAX - RMIN + 1);
        if (t < RMIN) return t + (RMAX - RMIN + 1);
        return t;
    endfunction

    function automatic logic [1:0] dir_of(input logic [1:0] code,
        input logic signed [31:0] t, input logic signed [31:0] a);
        int d;
        d = (t - a) % (RMAX - RMIN + 1);
        if (d < 0) d = d + RMAX - RMIN + 1;
        case (code)
            ROT_LINEAR: return (t >= a) ? DIR_POS : DIR_NEG;
            ROT_NEG_ONLY: return DIR_NEG;
            ROT_POS_ONLY: return DIR_POS;
            default: return (d < (RMAX - RMIN + 1) / 2) ? DIR_POS : DIR_NEG;
        endcase
    endfunction

    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h not %h", $time, what,
                     got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp,
        input string what);
        check_word({31'h0, got}, {31'h0, exp}, what);
    endtask

    // 0 start pulse, 1 request bit cleared, 2 ack dropped
    task automatic wait_for(input int sel);
        int n;
        for (n = 0; n < 50; n++) begin
            @(posedge clock);
            #1;
            if (sel == 0 ? move_start : sel == 1 ?
                !ctrl_word[CTRL_NEW_SETPOINT] : !setpoint_ack) return;
        end
        fail_count++;
        $display("wrong value at %0t: wait %0d timed out", $time, sel);
        results();
    endtask

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    initial begin
        rst_n = 1'b0;
        {neg, pos, home, general_input} = 11'h0;
        {setpoint_ready, target_reached} = 2'b10;
        {target_position, ramp_output, actual_position} = 96'h0;
        {fail_count, comparisons} = 64'h0;
        prev_t = 32'sd0;
        void'($urandom(32'h74a6ec74));
        repeat (12) @(posedge clock);
        #1;
        rst_n = 1'b1;
        for (i = 0; i < 3; i++) begin
            master.access(IDX[i], 1'b0, 32'h0, rd, ok, er);
            check_word(rd, RST[i], "reset value");
            check_flag(ok, 1'b1, "read answer");
        end
        for (i = 0; i < 60; i++) begin
            {neg, pos, home, general_input} = 11'($urandom);
            {rel, rls} = {2'($urandom % 3), 2'($urandom % 3)};
            {rot, relv} = 3'($urandom);
            target_position = 32'($urandom % 1000) - 32'd500;
            ramp_output = 32'($urandom % 2000) - 32'd1000;
            actual_position = 32'($urandom % 2000) - 32'd1000;
            opt = {8'h0, rot, rls, 2'h0, rel};
            master.access(IDX_POS_OPTION, 1'b1, {16'h0, opt}, rd, ok, er);
            master.access(IDX_POS_OPTION, 1'b0, 32'h0, rd, ok, er);
            check_word(rd, {16'h0, opt}, "option word");
            base = !relv ? 32'sd0 : rel == REL_PREV_TARGET ? prev_t :
                   rel == REL_RAMP_OUTPUT ? ramp_output : actual_position;
            exp_t = wrap(base + target_position);
            setpoint_ready = 1'($urandom);
            master.control({9'h0, relv, 6'h10});
            if (!setpoint_ready) begin
                repeat (3) @(posedge clock);
                #1;
                check_flag(move_start, 1'b0, "start while busy");
                setpoint_ready = 1'b1;
            end
            wait_for(0);
            check_word(move_target, exp_t, "target");
            check_word(30'h0 + move_direction,
                       dir_of(rot, exp_t, actual_position),
                       "direction");
            check_flag(setpoint_ack, 1'b1, "ack");
            prev_t = exp_t;
            if (rls != RELEASE_ASAP) begin
                repeat (3) @(posedge clock);
                #1;
                check_flag(ctrl_word[CTRL_NEW_SETPOINT], 1'b1, "held");
            end
            if (rls == RELEASE_HOST) begin
                master.control({9'h0, relv, 6'h00});
                wait_for(2);
            end else begin
                target_reached = 1'b1;
                wait_for(1);
                check_flag(setpoint_ack, 1'b1, "ack after clear");
                @(posedge clock);
                #1;
                check_flag(setpoint_ack, 1'b0, "ack release");
                target_reached = 1'b0;
            end
            master.access(IDX_FOLLOW_ERR, 1'b0, 32'h0, rd, ok, er);
            check_word(rd, ramp_output - actual_position, "error");
            master.access(IDX_INPUT_LEVEL, 1'b0, 32'h0, rd, ok, er);
            check_word(rd, {8'h0, general_input & MASK, 13'h0, home, pos,
                       neg}, "inputs");
            master.access(i[0] ? IDX_INPUT_LEVEL : IDX_FOLLOW_ERR, 1'b1,
                          $urandom, rd, ok, er);
            check_flag(er, 1'b1, "read-only write");
        end
        master.access(16'h6100, 1'b0, 32'h0, rd, ok, er);
        check_flag(er, 1'b1, "unmapped read");
        results();
    end
endmodule
